// ===== uvfr_pkg.sv
`default_nettype none

// ---------------------------------------------------------------------------
// Shared constants for the output under-voltage fault response block.
// ---------------------------------------------------------------------------
package uvfr_pkg;

  // Command code of the response byte and its value after reset.
  localparam logic [7:0] UVFR_CMD_CODE = 8'h45;
  localparam logic [7:0] UVFR_RESET    = 8'h00;

  // Field positions inside the response byte.
  localparam int UVFR_MODE_MSB = 7;
  localparam int UVFR_MODE_LSB = 6;
  localparam int UVFR_RTRY_MSB = 5;
  localparam int UVFR_RTRY_LSB = 3;
  localparam int UVFR_DLY_MSB  = 2;
  localparam int UVFR_DLY_LSB  = 0;

  // Response modes.
  localparam logic [1:0] UVFR_MODE_IGNORE = 2'h0;
  localparam logic [1:0] UVFR_MODE_DELAY  = 2'h1;
  localparam logic [1:0] UVFR_MODE_SHUT   = 2'h2;
  localparam logic [1:0] UVFR_MODE_HOLD   = 2'h3;

  // Restart count codes with a special meaning.
  localparam logic [2:0] UVFR_RTRY_NONE = 3'h0;
  localparam logic [2:0] UVFR_RTRY_CONT = 3'h7;

  // Response states.
  typedef enum logic [2:0] {
    UVFR_ST_RUN,
    UVFR_ST_DELAY,
    UVFR_ST_HOLD,
    UVFR_ST_RETRY,
    UVFR_ST_LATCHED
  } uvfr_state_t;

endpackage

`default_nettype wire

// ===== uvfr_core.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Byte register at code 0x45, readable and writable, picks fault handling.
// - Bits 7:6 hold the response mode, bits 5:3 the restart count.
// - Mode 00 keeps the output running through the fault.
// - Mode 01 runs for the delay, then restarts per count if fault remains.
// - Mode 10 disables the output at once, then follows the restart count.
// - Mode 11 keeps the output off while the fault lasts, then resumes.
// - Restart count 000 means no restarts; off until the fault is cleared.
// - Counts 1 to 6 give that many restarts, then off until cleared.
// - Count 111 restarts without limit.
// - Restart attempt starts are spaced by 2 to the power of the delay code, in time units.
// - Clear by bit clear, clear-faults, reset, or output off then on.
// - Delay codes 0 to 7 mean 1, 2, 4 ... 128 time units.
// - Restarting stops when commanded off or another fault shuts down.
module uvfr_core (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       cmd_wr_i,
  input  wire logic       cmd_rd_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic [7:0] cmd_wdata_i,
  output var  logic [7:0] cmd_rdata_o,
  input  wire logic       uv_fault_i,
  input  wire logic       other_fault_i,
  input  wire logic       unit_tick_i,
  input  wire logic       op_on_i,
  input  wire logic       ctrl_pin_i,
  input  wire logic       clear_bit_i,
  input  wire logic       clear_faults_i,
  output var  logic       out_en_o,
  output var  logic       uv_flag_o
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------

  // Delay code to number of time units, a power of two.
  function automatic logic [7:0] dly_units(input logic [2:0] code);
    dly_units = 8'h01 << code;
  endfunction

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  logic [7:0]           cfg_q;
  logic                 ctrl_s1_q;
  logic                 ctrl_s2_q;
  logic                 cmd_on_q;
  logic                 cmd_on;
  logic                 on_rise;
  logic                 clear_evt;
  logic [1:0]           mode;
  logic [2:0]           rtry;
  logic [7:0]           tgt;
  logic                 done;
  logic                 fail_now;
  uvfr_pkg::uvfr_state_t st_q;
  uvfr_pkg::uvfr_state_t st_d;
  logic [7:0]           cnt_q;
  logic [7:0]           cnt_d;
  logic [2:0]           left_q;
  logic [2:0]           left_d;
  logic                 fail_q;
  logic                 fail_d;
  logic                 en_d;

  // -------------------------------------------------------------------------
  // Configuration byte
  // -------------------------------------------------------------------------

  // The byte is written and read only at its own command code.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= uvfr_pkg::UVFR_RESET;
    end else if (cmd_wr_i && cmd_code_i == uvfr_pkg::UVFR_CMD_CODE) begin
      cfg_q <= cmd_wdata_i;
    end
  end

  // Read data is registered; other codes answer zero so the engine sees
  // a defined value.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_rdata_o <= 8'h00;
    end else if (cmd_rd_i) begin
      cmd_rdata_o <= (cmd_code_i == uvfr_pkg::UVFR_CMD_CODE) ? cfg_q : 8'h00;
    end
  end

  // Field extraction; the restart count is always bits 5:3.
  assign mode = cfg_q[uvfr_pkg::UVFR_MODE_MSB:uvfr_pkg::UVFR_MODE_LSB];
  assign rtry = cfg_q[uvfr_pkg::UVFR_RTRY_MSB:uvfr_pkg::UVFR_RTRY_LSB];
  assign tgt  = dly_units(cfg_q[uvfr_pkg::UVFR_DLY_MSB:uvfr_pkg::UVFR_DLY_LSB]);

  // -------------------------------------------------------------------------
  // On/off command and clear events
  // -------------------------------------------------------------------------

  // The control pin is asynchronous, so it passes two flip-flops first.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_s1_q <= 1'b0;
      ctrl_s2_q <= 1'b0;
      cmd_on_q  <= 1'b0;
    end else begin
      ctrl_s1_q <= ctrl_pin_i;
      ctrl_s2_q <= ctrl_s1_q;
      cmd_on_q  <= cmd_on;
    end
  end

  // Output is commanded on only when both pin and command agree.
  assign cmd_on    = ctrl_s2_q && op_on_i;
  assign on_rise   = cmd_on && !cmd_on_q;
  assign clear_evt = clear_bit_i || clear_faults_i || on_rise;

  // -------------------------------------------------------------------------
  // Status flag
  // -------------------------------------------------------------------------

  // Detection wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_flag_o <= 1'b0;
    end else if (uv_fault_i) begin
      uv_flag_o <= 1'b1;
    end else if (clear_evt) begin
      uv_flag_o <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Response state machine
  // -------------------------------------------------------------------------

  // Each retry interval after the first starts an attempt with the output on; a fault seen
  // during it turns the output off and marks the attempt failed. Spacing the
  // starts by the interval means a failed attempt sits off until the next.
  assign done     = unit_tick_i && ((cnt_q + 8'h01) == tgt);
  assign fail_now = fail_q || uv_fault_i;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    left_d = left_q;
    fail_d = fail_q;
    case (st_q)
      uvfr_pkg::UVFR_ST_RUN: begin
        cnt_d = 8'h00;
        if (uv_fault_i) begin
          case (mode)
            uvfr_pkg::UVFR_MODE_IGNORE: st_d = uvfr_pkg::UVFR_ST_RUN;
            uvfr_pkg::UVFR_MODE_DELAY:  st_d = uvfr_pkg::UVFR_ST_DELAY;
            uvfr_pkg::UVFR_MODE_HOLD:   st_d = uvfr_pkg::UVFR_ST_HOLD;
            default: begin
              // Immediate shutdown, then the restart count decides.
              fail_d = 1'b1;
              left_d = rtry;
              st_d   = (rtry == uvfr_pkg::UVFR_RTRY_NONE) ?
                       uvfr_pkg::UVFR_ST_LATCHED : uvfr_pkg::UVFR_ST_RETRY;
            end
          endcase
        end
      end
      uvfr_pkg::UVFR_ST_DELAY: begin
        if (!uv_fault_i) begin
          st_d = uvfr_pkg::UVFR_ST_RUN;
        end else if (done) begin
          cnt_d  = 8'h00;
          fail_d = 1'b1;
          left_d = rtry;
          st_d   = (rtry == uvfr_pkg::UVFR_RTRY_NONE) ?
                   uvfr_pkg::UVFR_ST_LATCHED : uvfr_pkg::UVFR_ST_RETRY;
        end else if (unit_tick_i) begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      uvfr_pkg::UVFR_ST_HOLD: begin
        if (!uv_fault_i) begin
          st_d = uvfr_pkg::UVFR_ST_RUN;
        end
      end
      uvfr_pkg::UVFR_ST_RETRY: begin
        fail_d = fail_now;
        if (done) begin
          cnt_d = 8'h00;
          if (!fail_now) begin
            st_d = uvfr_pkg::UVFR_ST_RUN;
          end else if (left_q == 3'h0) begin
            st_d = uvfr_pkg::UVFR_ST_LATCHED;
          end else begin
            fail_d = 1'b0;
            if (left_q != uvfr_pkg::UVFR_RTRY_CONT) begin
              left_d = left_q - 3'h1;
            end
          end
        end else if (unit_tick_i) begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      uvfr_pkg::UVFR_ST_LATCHED: begin
        st_d = uvfr_pkg::UVFR_ST_LATCHED;
      end
      default: begin
        st_d = uvfr_pkg::UVFR_ST_RUN;
      end
    endcase
    // Overrides: a clear restarts normal operation; commanding off or a
    // foreign shutdown ends any restart sequence.
    if (clear_evt) begin
      st_d  = uvfr_pkg::UVFR_ST_RUN;
      cnt_d = 8'h00;
    end else if (!cmd_on && st_q != uvfr_pkg::UVFR_ST_LATCHED) begin
      st_d  = uvfr_pkg::UVFR_ST_RUN;
      cnt_d = 8'h00;
    end else if (other_fault_i && st_q == uvfr_pkg::UVFR_ST_RETRY) begin
      st_d = uvfr_pkg::UVFR_ST_LATCHED;
    end
  end

  // The output is on only while commanded on and in an operating state.
  assign en_d = cmd_on && (st_d == uvfr_pkg::UVFR_ST_RUN ||
                           st_d == uvfr_pkg::UVFR_ST_DELAY ||
                           (st_d == uvfr_pkg::UVFR_ST_RETRY && !fail_d));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q     <= uvfr_pkg::UVFR_ST_RUN;
      cnt_q    <= 8'h00;
      left_q   <= 3'h0;
      fail_q   <= 1'b0;
      out_en_o <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      left_q   <= left_d;
      fail_q   <= fail_d;
      out_en_o <= en_d;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------

  property p_rd_cfg;
    @(posedge mclk_i) disable iff (rst_i)
    cmd_rd_i && cmd_code_i == uvfr_pkg::UVFR_CMD_CODE |=>
      cmd_rdata_o == $past(cfg_q);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("Read of the response byte returned a wrong value.");

  property p_wr_cfg;
    @(posedge mclk_i) disable iff (rst_i)
    cmd_wr_i && cmd_code_i == uvfr_pkg::UVFR_CMD_CODE |=>
      mode == $past(cmd_wdata_i[7:6]) && rtry == $past(cmd_wdata_i[5:3]);
  endproperty
  a_wr_cfg: assert property (p_wr_cfg)
    else $error("Written mode or restart field not held.");

  property p_ignore;
    @(posedge mclk_i) disable iff (rst_i)
    st_q == uvfr_pkg::UVFR_ST_RUN && mode == uvfr_pkg::UVFR_MODE_IGNORE &&
      cmd_on && uv_fault_i ##1 cmd_on |-> out_en_o;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Output dropped in ignore mode.");

  property p_shut;
    @(posedge mclk_i) disable iff (rst_i)
    st_q == uvfr_pkg::UVFR_ST_RUN && mode == uvfr_pkg::UVFR_MODE_SHUT &&
      uv_fault_i && !clear_evt |=> !out_en_o;
  endproperty
  a_shut: assert property (p_shut)
    else $error("Output not disabled at once in shutdown mode.");

  property p_hold_end;
    @(posedge mclk_i) disable iff (rst_i)
    st_q == uvfr_pkg::UVFR_ST_HOLD && !uv_fault_i |=>
      st_q == uvfr_pkg::UVFR_ST_RUN;
  endproperty
  a_hold_end: assert property (p_hold_end)
    else $error("Hold mode did not resume after the fault left.");

  property p_no_retry;
    @(posedge mclk_i) disable iff (rst_i)
    st_q == uvfr_pkg::UVFR_ST_RUN && mode == uvfr_pkg::UVFR_MODE_SHUT &&
      rtry == uvfr_pkg::UVFR_RTRY_NONE && uv_fault_i && cmd_on && !clear_evt
      |=> st_q == uvfr_pkg::UVFR_ST_LATCHED && !out_en_o;
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("Zero restart count did not latch off.");

  property p_flag_set;
    @(posedge mclk_i) disable iff (rst_i)
    uv_fault_i |=> uv_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Fault flag not set on detection.");

  property p_flag_clr;
    @(posedge mclk_i) disable iff (rst_i)
    clear_faults_i && !uv_fault_i |=> !uv_flag_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("Fault flag not cleared by clear-faults.");

  property p_off_stops;
    @(posedge mclk_i) disable iff (rst_i)
    !cmd_on |=> !out_en_o && st_q != uvfr_pkg::UVFR_ST_RETRY;
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("Restarting continued while commanded off.");

  property p_dly_end;
    @(posedge mclk_i) disable iff (rst_i)
    st_q == uvfr_pkg::UVFR_ST_DELAY && uv_fault_i && done && cmd_on &&
      !clear_evt |=> !out_en_o;
  endproperty
  a_dly_end: assert property (p_dly_end)
    else $error("Output not shut down at end of fault delay.");

endmodule

`default_nettype wire

// ===== uvfr_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------------
// Far side: the fault time base and the remote on/off control pin.
// ---------------------------------------------------------------------------
module uvfr_far_model (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic lclk_i,
  input  wire logic pin_req_i,
  output var  logic unit_tick_o,
  output var  logic ctrl_pin_o
);
  logic [1:0] div_q;

  // One time unit every four clocks keeps the retry waits short.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q       <= 2'h0;
      unit_tick_o <= 1'b0;
    end else begin
      div_q       <= div_q + 2'h1;
      unit_tick_o <= (div_q == 2'h3);
    end
  end

  // The pin moves on the slow clock, so its edges land at any phase.
  initial ctrl_pin_o = 1'b0;
  always @(posedge lclk_i) begin
    ctrl_pin_o <= pin_req_i;
  end
endmodule

`default_nettype wire

// ===== undervoltage_fault_response_tb.sv
`timescale 1ns/100ps
`default_nettype none

module undervoltage_fault_response_tb;
  localparam int TICK = 4;
  logic       mclk, lclk, rst, wr, rd, uv, oth, op, pin_req, clr_b, clr_a;
  logic [7:0] code, wdata, rdata, rv;
  logic       tick, pin, en, flag, en_prev;
  int         num_errors = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         rises = 0;
  int         t_last = 0;
  int         gap = 0;
  int         r0;
  logic [2:0] d;

  // ---------------------------------------------------------------------
  // Clocks, design and far side.
  // ---------------------------------------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // Slow clock is offset so its edges never align with the system clock.
  initial begin
    lclk = 1'b0;
    #3;
    forever #80 lclk = ~lclk;
  end

  uvfr_core u_dut (
    .mclk_i(mclk), .rst_i(rst), .cmd_wr_i(wr), .cmd_rd_i(rd),
    .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata),
    .uv_fault_i(uv), .other_fault_i(oth), .unit_tick_i(tick),
    .op_on_i(op), .ctrl_pin_i(pin), .clear_bit_i(clr_b),
    .clear_faults_i(clr_a), .out_en_o(en), .uv_flag_o(flag)
  );

  uvfr_far_model u_far (
    .mclk_i(mclk), .rst_i(rst), .lclk_i(lclk), .pin_req_i(pin_req),
    .unit_tick_o(tick), .ctrl_pin_o(pin)
  );

  // Counts restart attempts and the spacing of their starts.
  always @(posedge mclk) begin
    en_prev <= en;
    cyc <= cyc + 1;
    if (en === 1'b1 && en_prev === 1'b0) begin
      rises <= rises + 1;
      gap <= cyc - t_last;
      t_last <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [7:0] c, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    code <= c;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd_reg(input logic [7:0] c, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    code <= c;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask

  // Commands the output off and on again by pin or by command.
  task automatic off_on(input logic by_pin);
    @(posedge mclk);
    if (by_pin) pin_req <= 1'b0;
    else op <= 1'b0;
    cycles(40);
    check({7'h00, en}, 8'h00);
    if (by_pin) pin_req <= 1'b1;
    else op <= 1'b1;
    cycles(40);
  endtask

  // ---------------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------------
  initial begin
    {wr, rd, uv, oth, clr_b, clr_a, pin_req} = 7'h00;
    op = 1'b1;
    code = 8'h00;
    wdata = 8'h00;
    rst = 1'b1;
    cycles(3);
    rst <= 1'b0;
    pin_req <= 1'b1;
    @(posedge mclk);
    check({6'h00, en, flag}, 8'h00);
    rd_reg(8'h45, rv);
    check(rv, 8'h00);
    cycles(40);
    check({7'h00, en}, 8'h01);
    // Register access, including a write and a read of an unmapped code.
    wr_reg(8'h45, 8'ha5);
    wr_reg(8'h46, 8'hff);
    rd_reg(8'h45, rv);
    check(rv, 8'ha5);
    rd_reg(8'h46, rv);
    check(rv, 8'h00);
    wr_reg(8'h45, 8'h00);
    // Ignore mode keeps running but still flags; bit clear drops the flag.
    uv <= 1'b1;
    cycles(10);
    check({6'h00, en, flag}, 8'h03);
    uv <= 1'b0;
    clr_b <= 1'b1;
    @(posedge mclk);
    clr_b <= 1'b0;
    cycles(2);
    check({7'h00, flag}, 8'h00);
    // Off while the fault lasts, back on once it has gone.
    wr_reg(8'h45, 8'hc0);
    uv <= 1'b1;
    cycles(3);
    check({6'h00, en, flag}, 8'h01);
    uv <= 1'b0;
    cycles(3);
    check({7'h00, en}, 8'h01);
    // Shut down with no retry stays off until the clear-faults command.
    wr_reg(8'h45, 8'h80);
    uv <= 1'b1;
    @(posedge mclk);
    uv <= 1'b0;
    cycles(2);
    check({7'h00, en}, 8'h00);
    cycles(40);
    check({7'h00, en}, 8'h00);
    clr_a <= 1'b1;
    @(posedge mclk);
    clr_a <= 1'b0;
    cycles(3);
    check({6'h00, en, flag}, 8'h02);
    // Delayed action: runs for two units, then shuts down.
    wr_reg(8'h45, 8'h41);
    uv <= 1'b1;
    cycles(3);
    check({7'h00, en}, 8'h01);
    cycles(20);
    check({7'h00, en}, 8'h00);
    uv <= 1'b0;
    off_on(1'b0);
    check({6'h00, en, flag}, 8'h02);
    // Each restart count 1 to 7 with a standing fault, varied delay codes.
    for (int n = 1; n <= 7; n++) begin
      d = 3'(n % 4);
      wr_reg(8'h45, {2'h2, 3'(n), d});
      r0 = rises;
      uv <= 1'b1;
      cycles(300);
      if (n < 7) begin
        check(8'(rises - r0), 8'(n));
        check({7'h00, en}, 8'h00);
      end else begin
        check({7'h00, (rises - r0) > 7}, 8'h01);
        oth <= 1'b1;
        @(posedge mclk);
        oth <= 1'b0;
        uv <= 1'b0;
        cycles(50);
        check({7'h00, en}, 8'h00);
      end
      if (n >= 2) check(8'(gap), 8'(TICK << d));
      uv <= 1'b0;
      off_on(n[0]);
      check({6'h00, en, flag}, 8'h02);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
